// ===== rtl/ser_status.sv
`timescale 1ns/1ps
`default_nettype none
module ser_status (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic clk_en, // Freezes all state while low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction.
  input wire logic [ser_pkg::SER_AW-1:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped or illegal write.
  input wire logic [7:0] std_event_in, // Standard event pulses.
  input wire logic [7:0] opr_cond_in, // Live operation conditions.
  input wire logic msg_avail, // Output queue holds a message.
  output logic srq_out, // Bus service-request line.
  output logic irq // Level interrupt to local software.
);
  import ser_pkg::*;

  logic [7:0] std_evt_q, std_ena_q, opr_evt_q, opr_ena_q, sre_q;
  logic rqs_q, req_prev_q, rdy_q;
  logic [7:0] istat_q, imask_q;
  logic [7:0] stb_w;
  logic esb, osb, mss;
  logic acc, wr, rd, cls, poll;
  logic [7:0] rd_byte;
  logic hit, bad_wr;
  logic [4:0] a;

  assign a = paddr[4:0];
  // A transfer takes effect only at the edge where pready is seen high.
  assign acc = psel & penable & rdy_q & clk_en;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign cls = wr && a == SER_CTRL_OFF && pwdata[SER_CTRL_CLS];
  assign poll = wr && a == SER_CTRL_OFF && pwdata[SER_CTRL_POLL];
  // One wait state lets the read byte reach its flip-flops before pready is shown.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_q <= 1'b0;
    end else if (clk_en) begin
      rdy_q <= psel & penable & ~rdy_q;
    end
  end
  assign pready = psel & penable & rdy_q;

  assign esb = |(std_evt_q & std_ena_q);
  assign osb = |(opr_evt_q & opr_ena_q);
  // Summary bits are pure wiring so the byte never holds stale state.
  always_comb begin
    stb_w = 8'h00;
    stb_w[SER_STB_OSB] = osb;
    stb_w[SER_STB_ESB] = esb;
    stb_w[SER_STB_MAV] = msg_avail;
    mss = |(stb_w & sre_q & ~(8'h01 << SER_STB_MSS));
    stb_w[SER_STB_MSS] = mss;
  end

  // Event set wins over a clear in the same cycle, so no event is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      std_evt_q <= SER_RST8;
    end else if (clk_en) begin
      if (cls) begin
        std_evt_q <= std_event_in;
      end else if (rd && a == SER_STD_EVT_OFF) begin
        // Only the bits already reported are cleared, so an event in the wait state survives.
        std_evt_q <= (std_evt_q & ~prdata[7:0]) | std_event_in;
      end else begin
        std_evt_q <= std_evt_q | std_event_in;
      end
    end
  end

  // The operation event register latches rising conditions; plain clear-status clears it.
  logic [7:0] cond_prev_q, opr_rise;
  assign opr_rise = opr_cond_in & ~cond_prev_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opr_evt_q <= SER_RST8;
      cond_prev_q <= SER_RST8;
    end else if (clk_en) begin
      cond_prev_q <= opr_cond_in;
      if (cls) begin
        opr_evt_q <= opr_rise;
      end else if (rd && a == SER_OPR_EVT_OFF) begin
        opr_evt_q <= (opr_evt_q & ~prdata[7:0]) | opr_rise;
      end else begin
        opr_evt_q <= opr_evt_q | opr_rise;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      std_ena_q <= SER_RST8;
      opr_ena_q <= SER_RST8;
      sre_q <= SER_RST8;
      imask_q <= SER_RST8;
    end else if (wr) begin
      if (a == SER_STD_ENA_OFF) begin
        std_ena_q <= pwdata[7:0];
      end else if (a == SER_OPR_ENA_OFF) begin
        opr_ena_q <= pwdata[7:0];
      end else if (a == SER_SRE_OFF) begin
        sre_q <= pwdata[7:0];
      end else if (a == SER_CTRL_OFF + 5'h01) begin
        imask_q <= pwdata[7:0];
      end
    end
  end

  // Request function arms on a rising master summary and is dropped by a poll.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rqs_q <= 1'b0;
      req_prev_q <= 1'b0;
    end else if (clk_en) begin
      req_prev_q <= mss;
      if (mss && !req_prev_q) begin
        rqs_q <= 1'b1;
      end else if (poll || !mss) begin
        rqs_q <= 1'b0;
      end
    end
  end
  assign srq_out = rqs_q;

  // Interrupt status: bit0 master summary rise, bit1 standard event, bit2 operation event.
  logic [7:0] ievt;
  assign ievt = {5'h00, |opr_rise, |std_event_in, mss & ~req_prev_q};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_q <= SER_RST8;
    end else if (clk_en) begin
      if (wr && a == SER_CTRL_OFF + 5'h02) begin
        istat_q <= (istat_q & ~pwdata[7:0]) | ievt;
      end else begin
        istat_q <= istat_q | ievt;
      end
    end
  end
  assign irq = |(istat_q & imask_q);

  always_comb begin
    hit = 1'b1;
    if (a == SER_STD_EVT_OFF) begin
      rd_byte = std_evt_q;
    end else if (a == SER_STD_ENA_OFF) begin
      rd_byte = std_ena_q;
    end else if (a == SER_OPR_COND_OFF) begin
      rd_byte = opr_cond_in;
    end else if (a == SER_OPR_EVT_OFF) begin
      rd_byte = opr_evt_q;
    end else if (a == SER_OPR_ENA_OFF) begin
      rd_byte = opr_ena_q;
    end else if (a == SER_STB_OFF) begin
      rd_byte = stb_w;
    end else if (a == SER_SRE_OFF) begin
      rd_byte = sre_q;
    end else if (a == SER_CTRL_OFF) begin
      rd_byte = 8'h00;
    end else if (a == SER_CTRL_OFF + 5'h01) begin
      rd_byte = imask_q;
    end else if (a == SER_CTRL_OFF + 5'h02) begin
      rd_byte = istat_q;
    end else begin
      rd_byte = 8'h00;
      hit = 1'b0;
    end
  end
  // Address 0x1d/0x1e are unaligned, so mask and status use hit checks below.
  assign bad_wr = pwrite && (a == SER_STD_EVT_OFF || a == SER_OPR_COND_OFF
    || a == SER_OPR_EVT_OFF || a == SER_STB_OFF);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (clk_en && psel && penable && !pwrite && !rdy_q) begin
      prdata <= {24'h0, rd_byte};
    end
  end
  assign pslverr = psel & penable & ((~hit & ~(a == SER_CTRL_OFF + 5'h01)
    & ~(a == SER_CTRL_OFF + 5'h02)) | bad_wr);
endmodule : ser_status
`default_nettype wire

// ===== rtl/ser_pkg.sv
// What this block does
// - Condition registers show live instrument state, unlatched, and are read-only.
// - Operation set has a condition register; standard event set has none.
// - Event bits latch to one on their event; software cannot write them.
// - A further event on an already set bit changes nothing but the interrupt status.
// - Event bits stay set until cleared; standard event register clears on query.
// - Clear-status clears standard and operation event registers together.
// - Each set's enable register is writable and reads back.
// - Set summary is high when any event bit and its enable bit are set.
// - Status byte is read-only, unlatched, and follows current summaries.
// - Master summary sets when any summary meets its service enable; drives request.
// - Service-request enable register is writable and reads back.
// - Queries return the 8 bits as a binary-weighted value, bit n weighs 2^n.
// - Enable registers and the interrupt mask take writes; interrupt status clears bits written one; other status registers are read-only.
// - Writing zero to an enable register clears all its bits.
// - Status byte has no direct clear; summaries clear with their event registers.
// - Standard-event summary is status bit 5; querying that register clears it.
// - Operation summary bit 7, master summary bit 6, message available bit 4.
// - Serial poll clears the request function but not the master summary.
package ser_pkg;
  localparam int unsigned SER_AW = 5;
  localparam logic [4:0] SER_STD_EVT_OFF = 5'h00;
  localparam logic [4:0] SER_STD_ENA_OFF = 5'h04;
  localparam logic [4:0] SER_OPR_COND_OFF = 5'h08;
  localparam logic [4:0] SER_OPR_EVT_OFF = 5'h0c;
  localparam logic [4:0] SER_OPR_ENA_OFF = 5'h10;
  localparam logic [4:0] SER_STB_OFF = 5'h14;
  localparam logic [4:0] SER_SRE_OFF = 5'h18;
  localparam logic [4:0] SER_CTRL_OFF = 5'h1c;
  localparam int unsigned SER_CTRL_CLS = 0;
  localparam int unsigned SER_CTRL_POLL = 1;
  localparam int unsigned SER_STB_OSB = 7;
  localparam int unsigned SER_STB_MSS = 6;
  localparam int unsigned SER_STB_ESB = 5;
  localparam int unsigned SER_STB_MAV = 4;
  localparam logic [7:0] SER_RST8 = 8'h00;
endpackage : ser_pkg

// ===== tb/ser_status_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ser_status_sva import ser_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ser_pkg::SER_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic msg_avail,
  input wire logic srq_out,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable && pready && clk_en;
  property p_rst; $rose(presetn) |-> !srq_out && !irq; endproperty
  a_rst: assert property (p_rst) else $error("outputs set after reset");
  property p_cond; acc && pwrite && paddr == SER_OPR_COND_OFF |-> pslverr; endproperty
  a_cond: assert property (p_cond) else $error("condition write taken");
  property p_evt; acc && pwrite && paddr == SER_STD_EVT_OFF |-> pslverr; endproperty
  a_evt: assert property (p_evt) else $error("event write taken");
  property p_stb; acc && pwrite && paddr == SER_STB_OFF |-> pslverr; endproperty
  a_stb: assert property (p_stb) else $error("status byte write taken");
  property p_sre; acc && pwrite && paddr == SER_SRE_OFF |-> !pslverr; endproperty
  a_sre: assert property (p_sre) else $error("enable write refused");
  property p_zero; acc && pwrite && paddr == SER_SRE_OFF && pwdata[7:0] == 8'h00
    |-> ##[1:2] !srq_out; endproperty
  a_zero: assert property (p_zero) else $error("request stays after zero");
  property p_poll; acc && pwrite && paddr == SER_CTRL_OFF && pwdata[SER_CTRL_POLL] |=> !srq_out;
  endproperty
  a_poll: assert property (p_poll) else $error("poll left request");
  property p_mav; acc && !pwrite && paddr == SER_STB_OFF
    |-> prdata[SER_STB_MAV] == $past(msg_avail) && prdata[31:8] == 24'h0; endproperty
  a_mav: assert property (p_mav) else $error("status byte read wrong");
endmodule : ser_status_sva
bind ser_status ser_status_sva i_ser_status_sva (.pclk(pclk), .presetn(presetn),
  .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .msg_avail(msg_avail),
  .srq_out(srq_out), .irq(irq));
`default_nettype wire

// ===== tb/ser_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ser_host_model (
  input wire logic pclk, // Bus clock.
  input wire logic pready, // Slave ready.
  input wire logic [31:0] prdata, // Read data.
  output logic psel = 1'h0, // Select.
  output logic penable = 1'h0, // Access phase.
  output logic pwrite = 1'h0, // Direction.
  output logic [4:0] paddr = 5'h00, // Byte address.
  output logic [31:0] pwdata = 32'h0 // Write data.
);
  // Called just after a rising edge; read data is taken at the edge where pready is high.
  task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] v,
                      output logic [31:0] r);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, v};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    r = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : xfer
endmodule : ser_host_model
`default_nettype wire

// ===== tb/status_event_reporting_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin bad_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module status_event_reporting_bench;
  import ser_pkg::*;
  logic pclk = 1'h0, presetn = 1'h0, msg_avail = 1'h0, psel, penable, pwrite, pready, pslverr;
  logic srq_out, irq;
  logic [4:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [7:0] std_ev = 8'h00, cond = 8'h00;
  logic [20:0] rows [6] = '{{SER_STD_ENA_OFF, 8'h5a, 8'h5a}, {SER_OPR_ENA_OFF, 8'ha5, 8'ha5},
    {SER_SRE_OFF, 8'h30, 8'h30}, {SER_STD_ENA_OFF, 8'h00, 8'h00},
    {SER_OPR_COND_OFF, 8'hff, 8'h00}, {5'h1f, 8'hff, 8'h00}};
  int bad_count = 0, cmp_count = 0;
  ser_status i_ser_status (.pclk(pclk), .presetn(presetn), .clk_en(1'h1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .std_event_in(std_ev), .opr_cond_in(cond),
    .msg_avail(msg_avail), .srq_out(srq_out), .irq(irq));
  ser_host_model i_ser_host_model (.pclk(pclk), .pready(pready), .prdata(prdata), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    i_ser_host_model.xfer(1'h1, a, v, d);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    i_ser_host_model.xfer(1'h0, a, 8'h00, d);
    `CHK("read", {24'h0, e}, d)
  endtask : rd
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  initial forever #5 pclk = ~pclk;
  initial begin
    #100us;
    bad_count++;
    end_of_test;
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rd(SER_SRE_OFF, 8'h00);
    rd(SER_STB_OFF, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i][20:16], rows[i][15:8]);
      rd(rows[i][20:16], rows[i][7:0]);
    end
    wr(SER_STD_ENA_OFF, 8'h20);
    wr(SER_SRE_OFF, 8'h20);
    wr(5'h1d, 8'h07);
    std_ev <= 8'h20; // Two cycles high: the repeat must be absorbed.
    repeat (2) @(posedge pclk);
    std_ev <= 8'h00;
    rd(SER_STB_OFF, 8'h60);
    `CHK("srq", 1'h1, srq_out)
    wr(SER_CTRL_OFF, 8'h02);
    `CHK("srq", 1'h0, srq_out)
    rd(SER_STB_OFF, 8'h60);
    rd(SER_STD_EVT_OFF, 8'h20);
    rd(SER_STB_OFF, 8'h00);
    i_ser_host_model.xfer(1'h0, 5'h1e, 8'h00, d);
    `CHK("irq status", 1'h1, d[0])
    wr(5'h1e, 8'hff);
    `CHK("irq", 1'h0, irq)
    wr(SER_OPR_ENA_OFF, 8'h01);
    wr(SER_SRE_OFF, 8'h80);
    cond <= 8'h01;
    @(posedge pclk);
    rd(SER_OPR_COND_OFF, 8'h01);
    rd(SER_STB_OFF, 8'hc0);
    wr(SER_CTRL_OFF, 8'h01);
    msg_avail <= 1'h1;
    @(posedge pclk);
    rd(SER_STB_OFF, 8'h10);
    end_of_test;
  end
endmodule : status_event_reporting_bench
`default_nettype wire
